// *** los_pkg.sv ***
// Purpose: shared constants, types and helpers for the upper-lane loss monitor
// Assumes: 10 MHz clock, Avalon-MM byte addressing, 8-bit registers in lane 0
// Notes:   register byte address is four times the register index
package los_pkg;

    // ==========================================================
    // geometry
    localparam int NUM_LANES  = 6;
    localparam int CODE_W     = 4;
    localparam int REG_W      = 8;
    localparam int ADDR_W     = 10;
    localparam int DATA_W     = 32;
    localparam int BE_W       = 4;
    localparam int CNT_W      = 10;
    localparam int NUM_DELAY  = 3;

    // ==========================================================
    // register indices (byte address is index * 4)
    localparam logic [7:0] IDX_DETECT_ON   = 8'h98;
    localparam logic [7:0] IDX_DELAY_7_6   = 8'h99;
    localparam logic [7:0] IDX_DELAY_9_8   = 8'h9a;
    localparam logic [7:0] IDX_DELAY_11_10 = 8'h9b;
    localparam logic [7:0] IDX_LOSS_LIVE   = 8'h9c;
    localparam logic [7:0] IDX_LOSS_LATCH  = 8'h9d;
    localparam logic [7:0] IDX_THRESHOLDS  = 8'h9e;
    localparam logic [7:0] IDX_IRQ_ON      = 8'h9f;

    // ==========================================================
    // reset values
    localparam logic [7:0] DELAY_RST      = 8'h99;
    localparam logic [7:0] THRESH_RST     = 8'h62;
    localparam logic [7:0] DETECT_ON_RST  = 8'h40;
    localparam logic [7:0] IRQ_ON_RST     = 8'h00;
    localparam logic [5:0] STATUS_RST     = 6'h00;
    localparam int         REF_ON_BIT     = 6;

    // ==========================================================
    // timing: delay table in tenths of a nanosecond
    localparam int CLK_PERIOD_TENTHS = 1000;
    localparam int DELAY_TENTHS [16] = '{
        25, 50, 100, 200, 400, 800, 1600, 3200,
        4600, 12800, 25600, 51200, 102400, 204800, 409600, 819200
    };

    typedef struct packed {
        logic [CODE_W-1:0] signal_return_threshold;
        logic [CODE_W-1:0] signal_drop_threshold;
    } thresholds_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } bus_req_t;

    typedef enum logic [1:0] {
        SQ_IDLE   = 2'b00,
        SQ_WAIT   = 2'b01,
        SQ_ACTIVE = 2'b11
    } squelch_state_t;

    // least delay, so round up; never below one cycle
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [CODE_W-1:0] code);
        int c;
        c = (DELAY_TENTHS[code] + CLK_PERIOD_TENTHS - 1) / CLK_PERIOD_TENTHS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

endpackage

// *** los_hysteresis.sv ***
// Purpose: per-lane loss detector with assert/deassert hysteresis
// Assumes: level code is the digitised input swing in 25 mV steps
// Notes:   a disabled detector holds its status at zero
`timescale 1ns/1ps
module los_hysteresis
    import los_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              detector_on,
    input  wire logic [CODE_W-1:0] level,
    input  wire thresholds_t       thresholds,
    output logic                   loss_r,
    output logic                   event_r
);

    // ==========================================================
    // status with hysteresis
    always_ff @(posedge clock) begin
        if (rst) begin
            loss_r <= 1'b0;
        end else if (!detector_on) begin
            loss_r <= 1'b0;
        end else if (level < thresholds.signal_drop_threshold) begin
            loss_r <= 1'b1;
        end else if (level > thresholds.signal_return_threshold) begin
            loss_r <= 1'b0;
        end
    end

    // one-cycle pulse on each new loss
    always_ff @(posedge clock) begin
        if (rst) begin
            event_r <= 1'b0;
        end else begin
            event_r <= detector_on && !loss_r && (level < thresholds.signal_drop_threshold);
        end
    end

endmodule

// *** los_squelch_timer.sv ***
// Purpose: delays the squelch of one transmit lane after a loss event
// Assumes: event is a one-cycle pulse, loss is the live status level
// Notes:   delay code is captured at the event; later writes act next event
`timescale 1ns/1ps
module los_squelch_timer
    import los_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              loss,
    input  wire logic              loss_event,
    input  wire logic [CODE_W-1:0] delay_code,
    output logic                   squelch_r
);

    squelch_state_t   state_r;
    logic [CNT_W-1:0] count_r;

    // ==========================================================
    // delay state machine
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r   <= SQ_IDLE;
            count_r   <= '0;
            squelch_r <= 1'b0;
        end else begin
            case (state_r)
                SQ_IDLE: begin
                    if (loss_event) begin
                        state_r <= SQ_WAIT;
                        count_r <= delay_cycles(delay_code);
                    end
                end
                SQ_WAIT: begin
                    if (!loss) begin
                        state_r <= SQ_IDLE;
                    end else if (count_r == CNT_W'(1)) begin
                        state_r   <= SQ_ACTIVE;
                        squelch_r <= 1'b1;
                    end else begin
                        count_r <= count_r - CNT_W'(1);
                    end
                end
                SQ_ACTIVE: begin
                    // signal back: release the transmitter at once
                    if (!loss) begin
                        state_r   <= SQ_IDLE;
                        squelch_r <= 1'b0;
                    end
                end
                default: begin
                    state_r   <= SQ_IDLE;
                    squelch_r <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** los_monitor_upper_lanes.sv ***
// Purpose: loss-of-signal monitor and squelch control for receive lanes 6 to 11
// Assumes: Avalon-MM slave, byte address, data in byte lane 0
// Notes:   every access answers with waitrequest low one cycle after it starts
//
// What this block does
// - one 4-bit squelch delay per lane, two lanes per register, high lane up
// - after a loss event, squelch the lane's transmitter after the coded delay
// - every squelch delay field resets to code 9, registers to 0x99
// - read-only live loss field, one bit per lane, 1 means no signal
// - live bit sets when the input level falls below the drop threshold
// - live bit clears above the return threshold or when the lane's detector is disabled; holds in between
// - read-only latched loss field, bit set by an event stays set until a read returns it
// - live and latched status reset to all zeros
// - threshold register: return code upper nibble, drop code lower nibble
// - threshold register resets to 0x62
// - a lane detects loss only while its detector enable bit is one
// - interrupt is the OR of latched loss bits gated by interrupt enables
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module los_monitor_upper_lanes
    import los_pkg::*;
(
    input  wire logic                             clock,
    input  wire logic                             rst,
    input  wire logic [ADDR_W-1:0]                address,
    input  wire logic                             read,
    input  wire logic                             write,
    input  wire logic [DATA_W-1:0]                writedata,
    input  wire logic [BE_W-1:0]                  byteenable,
    output logic      [DATA_W-1:0]                readdata,
    output logic                                  waitrequest,
    input  wire logic [NUM_LANES-1:0][CODE_W-1:0] lane_level,
    output logic      [NUM_LANES-1:0]             lane_squelch,
    output logic                                  loss_reference_on,
    output logic                                  irq
);

    // ==========================================================
    // register state
    bus_req_t                  req;
    logic [REG_W-1:0]          delay_r [NUM_DELAY];
    thresholds_t               thresholds_r;
    logic [REG_W-1:0]          detect_on_r;
    logic [REG_W-1:0]          irq_on_r;
    logic [NUM_LANES-1:0]      latched_r;
    logic [NUM_LANES-1:0]      latched_nxt;
    logic [NUM_LANES-1:0]      live_loss;
    logic [NUM_LANES-1:0]      loss_event;
    logic [DATA_W-1:0]         readdata_r;
    logic [DATA_W-1:0]         readdata_nxt;
    logic                      waitrequest_r;
    logic                      irq_r;
    logic                      take;
    logic                      wr_take;
    logic                      rd_take;
    logic                      wr_lane0;

    assign req.read       = read;
    assign req.write      = write;
    assign req.address    = address;
    assign req.writedata  = writedata;
    assign req.byteenable = byteenable;

    assign readdata          = readdata_r;
    assign waitrequest       = waitrequest_r;
    assign irq               = irq_r;
    assign loss_reference_on = detect_on_r[REF_ON_BIT];

    // ==========================================================
    // bus handshake
    // the request is taken at the edge where waitrequest is seen low
    assign take     = (req.read || req.write) && !waitrequest_r;
    assign wr_take  = take && req.write;
    assign rd_take  = take && req.read;
    assign wr_lane0 = wr_take && req.byteenable[0];

    always_ff @(posedge clock) begin
        if (rst) begin
            waitrequest_r <= 1'b1;
        end else begin
            // drop for exactly one cycle per request, then rise again
            waitrequest_r <= !((req.read || req.write) && waitrequest_r);
        end
    end

    // ==========================================================
    // read mux, registered one cycle ahead of the taking edge
    always_comb begin
        readdata_nxt = '0;
        if (req.address == reg_addr(IDX_DETECT_ON)) begin
            readdata_nxt[REG_W-1:0] = detect_on_r;
        end else if (req.address == reg_addr(IDX_DELAY_7_6)) begin
            readdata_nxt[REG_W-1:0] = delay_r[0];
        end else if (req.address == reg_addr(IDX_DELAY_9_8)) begin
            readdata_nxt[REG_W-1:0] = delay_r[1];
        end else if (req.address == reg_addr(IDX_DELAY_11_10)) begin
            readdata_nxt[REG_W-1:0] = delay_r[2];
        end else if (req.address == reg_addr(IDX_LOSS_LIVE)) begin
            readdata_nxt[NUM_LANES-1:0] = live_loss;
        end else if (req.address == reg_addr(IDX_LOSS_LATCH)) begin
            readdata_nxt[NUM_LANES-1:0] = latched_r;
        end else if (req.address == reg_addr(IDX_THRESHOLDS)) begin
            readdata_nxt[REG_W-1:0] = thresholds_r;
        end else if (req.address == reg_addr(IDX_IRQ_ON)) begin
            readdata_nxt[REG_W-1:0] = irq_on_r;
        end else begin
            readdata_nxt = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            readdata_r <= '0;
        end else if (req.read && waitrequest_r) begin
            readdata_r <= readdata_nxt;
        end
    end

    // ==========================================================
    // squelch delay registers
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_DELAY; i++) begin
                delay_r[i] <= DELAY_RST;
            end
        end else if (wr_lane0) begin
            if (req.address == reg_addr(IDX_DELAY_7_6)) begin
                delay_r[0] <= req.writedata[REG_W-1:0];
            end else if (req.address == reg_addr(IDX_DELAY_9_8)) begin
                delay_r[1] <= req.writedata[REG_W-1:0];
            end else if (req.address == reg_addr(IDX_DELAY_11_10)) begin
                delay_r[2] <= req.writedata[REG_W-1:0];
            end
        end
    end

    // ==========================================================
    // threshold register
    // ordering of the two codes is left to software; no check here
    always_ff @(posedge clock) begin
        if (rst) begin
            thresholds_r <= THRESH_RST;
        end else if (wr_lane0 && req.address == reg_addr(IDX_THRESHOLDS)) begin
            thresholds_r <= req.writedata[REG_W-1:0];
        end
    end

    // ==========================================================
    // detector enables and interrupt enables
    always_ff @(posedge clock) begin
        if (rst) begin
            detect_on_r <= DETECT_ON_RST;
        end else if (wr_lane0 && req.address == reg_addr(IDX_DETECT_ON)) begin
            detect_on_r <= req.writedata[REG_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_on_r <= IRQ_ON_RST;
        end else if (wr_lane0 && req.address == reg_addr(IDX_IRQ_ON)) begin
            irq_on_r <= req.writedata[REG_W-1:0];
        end
    end

    // ==========================================================
    // per-lane detectors and squelch timers
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        los_hysteresis u_detect (
            .clock       (clock),
            .rst         (rst),
            .detector_on (detect_on_r[g]),
            .level       (lane_level[g]),
            .thresholds  (thresholds_r),
            .loss_r      (live_loss[g]),
            .event_r     (loss_event[g])
        );

        // even lane in the low nibble, odd lane in the high nibble
        los_squelch_timer u_squelch (
            .clock      (clock),
            .rst        (rst),
            .loss       (live_loss[g]),
            .loss_event (loss_event[g]),
            .delay_code (delay_r[g/2][(g%2)*CODE_W +: CODE_W]),
            .squelch_r  (lane_squelch[g])
        );
    end

    // ==========================================================
    // latched loss with clear on read
    // only bits returned by the read are cleared; a new event wins
    always_comb begin
        latched_nxt = latched_r;
        if (rd_take && req.address == reg_addr(IDX_LOSS_LATCH)) begin
            latched_nxt = latched_r & ~readdata_r[NUM_LANES-1:0];
        end
        latched_nxt = latched_nxt | loss_event;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            latched_r <= STATUS_RST;
        end else begin
            latched_r <= latched_nxt;
        end
    end

    // ==========================================================
    // interrupt, registered so the pin is glitch free
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(latched_r & irq_on_r[NUM_LANES-1:0]);
        end
    end

endmodule

// *** los_monitor_upper_lanes_checker.sv ***
// Purpose: port assertions for the upper-lane loss monitor
// Assumes: shadows of written control registers follow the bus
// Notes:   lane checks allow three cycles of detector latency
`timescale 1ns/1ps
module los_monitor_checker
    import los_pkg::*;
(
    input wire logic                             clock,
    input wire logic                             rst,
    input wire logic [ADDR_W-1:0]                address,
    input wire logic                             read,
    input wire logic                             write,
    input wire logic [DATA_W-1:0]                writedata,
    input wire logic [BE_W-1:0]                  byteenable,
    input wire logic [DATA_W-1:0]                readdata,
    input wire logic                             waitrequest,
    input wire logic [NUM_LANES-1:0][CODE_W-1:0] lane_level,
    input wire logic [NUM_LANES-1:0]             lane_squelch,
    input wire logic                             loss_reference_on,
    input wire logic                             irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================
    // shadows of control registers
    logic [7:0] thr_r;
    logic [7:0] en_r;
    logic [7:0] irqen_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            thr_r   <= THRESH_RST;
            en_r    <= DETECT_ON_RST;
            irqen_r <= IRQ_ON_RST;
        end else if (write && !waitrequest && byteenable[0]) begin
            case (address)
                10'h260: en_r    <= writedata[7:0];
                10'h278: thr_r   <= writedata[7:0];
                10'h27c: irqen_r <= writedata[7:0];
                default: ;
            endcase
        end
    end
    // ==========================================
    // bus and status
    chk_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered in one cycle");
    chk_read_high_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_status_top_zero: assert property (
        read && !waitrequest && (address == 10'h270 || address == 10'h274)
        |-> readdata[7:6] == 2'h0)
        else $error("status top bits not zero");
    chk_reset_outputs: assert property (
        $fell(rst) |-> waitrequest && !irq && lane_squelch == 6'h00 && loss_reference_on)
        else $error("outputs not at reset values");
    chk_ref_mirror: assert property (loss_reference_on == en_r[REF_ON_BIT])
        else $error("reference enable differs from register");
    chk_irq_masked: assert property (irq |-> $past(irqen_r[5:0]) != 6'h00)
        else $error("interrupt with every lane masked");
    // ==========================================
    // lanes
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
        chk_return_clears: assert property (
            (lane_level[i] > thr_r[7:4])[*3] |=> !lane_squelch[i])
            else $error("squelch held after signal return");
        chk_disabled_quiet: assert property ((!en_r[i])[*3] |=> !lane_squelch[i])
            else $error("squelch on a disabled lane");
    end
    cov_irq: cover property ($rose(irq));
    cov_squelch: cover property ($rose(lane_squelch[1]));
    cov_latch_read: cover property (read && !waitrequest && address == 10'h274);
endmodule

bind los_monitor_upper_lanes los_monitor_checker i_los_monitor_checker (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lane_level(lane_level), .lane_squelch(lane_squelch),
    .loss_reference_on(loss_reference_on), .irq(irq));

// *** los_monitor_upper_lanes_bench.sv ***
// Purpose: self-checking bench for the upper-lane loss monitor
// Assumes: one access at a time, answered within the timeout
// Notes:   bus answer taken at the rising edge where waitrequest is seen low
`timescale 1ns/1ps
module los_monitor_upper_lanes_bench
    import los_pkg::*;
;
    logic                             clock;
    logic                             rst;
    logic [ADDR_W-1:0]                address;
    logic                             read;
    logic                             write;
    logic [DATA_W-1:0]                writedata;
    logic [BE_W-1:0]                  byteenable;
    logic [DATA_W-1:0]                readdata;
    logic                             waitrequest;
    logic [NUM_LANES-1:0][CODE_W-1:0] lane_level;
    logic [NUM_LANES-1:0]             lane_squelch;
    logic                             loss_reference_on;
    logic                             irq;
    int                               err_total = 0;
    int                               total_checks = 0;
    int                               cycles = 0;

    los_monitor_upper_lanes i_los_monitor_upper_lanes (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .lane_level(lane_level), .lane_squelch(lane_squelch),
        .loss_reference_on(loss_reference_on), .irq(irq));

    initial clock = 1'b0;
    always #50 clock = ~clock;
    // ==========================================
    // shared tasks
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one edge first, so a release is never overwritten in the same step
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic be, output logic [7:0] q);
        @(posedge clock);
        address    <= a;
        writedata  <= {24'h00_0000, d};
        byteenable <= {3'h0, be};
        read       <= !wr;
        write      <= wr;
        // hold the request until the edge that samples waitrequest low
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 1'b1, q);
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 1'b1, q);
        check(q, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset_vals;
        rd_chk(10'h260, DETECT_ON_RST);
        rd_chk(10'h264, 8'h99);
        rd_chk(10'h268, 8'h99);
        rd_chk(10'h26c, 8'h99);
        rd_chk(10'h270, 8'h00);
        rd_chk(10'h274, 8'h00);
        rd_chk(10'h278, 8'h62);
        rd_chk(10'h27c, 8'h00);
        rd_chk(10'h280, 8'h00);
    endtask
    task automatic t_regs_rw;
        logic [7:0] q;
        wr(10'h264, 8'h5a);
        wr(10'h268, 8'hc3);
        wr(10'h26c, 8'h18);
        bus(1'b1, 10'h268, 8'hff, 1'b0, q);
        wr(10'h270, 8'h3f);
        wr(10'h284, 8'h77);
        rd_chk(10'h264, 8'h5a);
        rd_chk(10'h268, 8'hc3);
        rd_chk(10'h26c, 8'h18);
        rd_chk(10'h270, 8'h00);
        rd_chk(10'h284, 8'h00);
        wr(10'h278, 8'h83);
        rd_chk(10'h278, 8'h83);
    endtask
    // return code 8, drop code 3; lane 7 stays disabled while low
    task automatic t_hyst;
        wr(10'h260, 8'h41);
        lane_level[0] <= 4'h3;
        lane_level[1] <= 4'h0;
        tick(3);
        rd_chk(10'h270, 8'h00);
        lane_level[0] <= 4'h2;
        tick(3);
        rd_chk(10'h270, 8'h01);
        lane_level[0] <= 4'h8;
        tick(3);
        rd_chk(10'h270, 8'h01);
        lane_level[0] <= 4'h9;
        lane_level[1] <= 4'ha;
        tick(3);
        rd_chk(10'h270, 8'h00);
    endtask
    task automatic t_latch_irq;
        check(irq, 1'b0);
        wr(10'h27c, 8'h01);
        tick(4);
        check(irq, 1'b1);
        rd_chk(10'h274, 8'h01);
        tick(3);
        check(irq, 1'b0);
        rd_chk(10'h274, 8'h00);
    endtask
    // lane 7 sits in the upper nibble of the first delay register
    task automatic t_squelch;
        logic [3:0] codes [4] = '{4'h0, 4'h8, 4'h9, 4'hf};
        int         tenths [4] = '{25, 4600, 12800, 819200};
        int         n;
        int         k;
        wr(10'h260, 8'h43);
        for (int j = 0; j < 4; j++) begin
            wr(10'h264, {codes[j], 4'h5});
            n = (tenths[j] + 999) / 1000;
            lane_level[1] <= 4'h1;
            k = 0;
            do begin
                @(negedge clock);
                k++;
            end while (lane_squelch[1] !== 1'b1 && k < 1000);
            check(k, n + 3);
            @(posedge clock);
            lane_level[1] <= 4'ha;
            tick(3);
            check(lane_squelch[1], 1'b0);
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        rst        = 1'b1;
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = '0;
        byteenable = '0;
        lane_level = {NUM_LANES{4'ha}};
        tick(10);
        rst <= 1'b0;
        t_reset_vals();
        t_regs_rw();
        t_hyst();
        t_latch_irq();
        t_squelch();
        conclude();
    end
endmodule
